// *** hdl/tmr_pkg.sv ***
// Purpose: Constants for the dual 8-bit timer/event counter
// Assumes: 32-bit classic Wishbone register port, one 100 MHz clock
// Notes:   Register data sits in the low byte, upper bits read zero
package tmr_pkg;
   localparam int          CLK_MHZ    = 100;
   localparam int          DIV_W      = 12;
   localparam int          CNT_W      = 8;
   localparam int          ADR_W      = 8;
   // Register byte addresses
   localparam logic [7:0]  OFS_CMP0   = 8'h00;
   localparam logic [7:0]  OFS_CMP1   = 8'h04;
   localparam logic [7:0]  OFS_CSEL0  = 8'h08;
   localparam logic [7:0]  OFS_CSEL1  = 8'h0C;
   localparam logic [7:0]  OFS_MODE0  = 8'h10;
   localparam logic [7:0]  OFS_MODE1  = 8'h14;
   localparam logic [7:0]  OFS_CNT0   = 8'h18;
   localparam logic [7:0]  OFS_CNT1   = 8'h1C;
   localparam logic [7:0]  OFS_STAT   = 8'h20;
   localparam logic [7:0]  OFS_MASK   = 8'h24;
   localparam logic [7:0]  OFS_CASC   = 8'h28;
   // Mode control fields
   localparam int          MC_RUN     = 7;
   localparam int          MC_PWM     = 6;
   localparam int          MC_SET     = 3;
   localparam int          MC_CLR     = 2;
   localparam int          MC_INV     = 1;
   localparam int          MC_OE      = 0;
   localparam logic [7:0]  MC_STORE   = 8'hC3;
   localparam logic [2:0]  CS_FALL    = 3'h0;
   localparam logic [2:0]  CS_RISE    = 3'h1;
   localparam logic [7:0]  CNT_TOP    = 8'hFF;
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   // Prescaler tap exponents per clock select code
   localparam int          TAP_CH0 [8] = '{0, 0, 3, 5, 7, 8, 9, 11};
   localparam int          TAP_CH1 [8] = '{0, 0, 4, 6, 7, 8, 10, 12};
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } tmr_bus_type;
endpackage : tmr_pkg

// *** hdl/tmr_dual.sv ***
// Purpose: Two 8-bit timer/event counters, cascadable to 16 bits
// Assumes: Event inputs synchronous to clk; Wishbone classic slave
// Notes:   Outputs registered; status clears on read, a new set wins
`timescale 1ns/1ns
`default_nettype none
module tmr_dual (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [tmr_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output var  logic [31:0]              wb_dat_o,
   output var  logic                     wb_ack_o,
   // Event inputs and timer outputs
   input  wire logic                     event_in_ch0,
   input  wire logic                     event_in_ch1,
   output var  logic                     timer_out_ch0,
   output var  logic                     timer_out_ch1,
   // Interrupts
   output var  logic                     match_irq_ch0,
   output var  logic                     match_irq_ch1,
   output var  logic                     irq
);
   import tmr_pkg::*;

   function automatic logic tap_hit(input logic [DIV_W-1:0] div, input int k);
      logic [DIV_W-1:0] m;
      m = DIV_W'((1 << k) - 1);
      return (div & m) == m;
   endfunction : tap_hit

   function automatic logic sel_tick(input logic [2:0] cs, input logic rise,
         input logic fall, input logic [DIV_W-1:0] div, input int ch);
      if (cs == CS_FALL)
         return fall;
      if (cs == CS_RISE)
         return rise;
      return tap_hit(div, (ch == 0) ? TAP_CH0[cs] : TAP_CH1[cs]);
   endfunction : sel_tick

   tmr_bus_type      bus_q, bus_d;
   logic [31:0]      rdat_q, rdat_d;
   logic [7:0]       cmp_q [2];
   logic [7:0]       cmp_d [2];
   logic [2:0]       cs_q [2];
   logic [2:0]       cs_d [2];
   logic [7:0]       mc_q [2];
   logic [7:0]       mc_d [2];
   logic [7:0]       cnt_q [2];
   logic [7:0]       cnt_d [2];
   logic [1:0]       ff_q, ff_d;
   logic [1:0]       ev_prev_q;
   logic [DIV_W-1:0] div_q, div_d;
   logic             casc_q, casc_d;
   logic [1:0]       stat_q, stat_d, mask_q, mask_d;
   logic [1:0]       tout_q, tout_d, mirq_q, mirq_d;
   logic             irq_q, irq_d;
   logic [1:0]       evin, tick, hit, run, wr_mc;
   logic             hit16, wr;

   assign evin = {event_in_ch1, event_in_ch0};
   assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & (bus_q == BUS_ACK);

   // Bus slave: ack one cycle after the request, write at the ack edge
   always_comb begin
      bus_d  = bus_q;
      rdat_d = rdat_q;
      unique case (bus_q)
         BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               bus_d  = BUS_ACK;
               rdat_d = '0;
               unique case (wb_adr_i)
                  OFS_CMP0:  rdat_d[7:0] = cmp_q[0];
                  OFS_CMP1:  rdat_d[7:0] = cmp_q[1];
                  OFS_CSEL0: rdat_d[2:0] = cs_q[0];
                  OFS_CSEL1: rdat_d[2:0] = cs_q[1];
                  OFS_MODE0: rdat_d[7:0] = mc_q[0];
                  OFS_MODE1: rdat_d[7:0] = mc_q[1];
                  OFS_CNT0:  rdat_d[7:0] = cnt_q[0];
                  OFS_CNT1:  rdat_d[7:0] = cnt_q[1];
                  OFS_STAT:  rdat_d[1:0] = stat_q;
                  OFS_MASK:  rdat_d[1:0] = mask_q;
                  OFS_CASC:  rdat_d[0]   = casc_q;
                  default:   rdat_d      = '0;
               endcase
            end
         end
         BUS_ACK: bus_d = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_q  <= BUS_IDLE;
         rdat_q <= '0;
      end else begin
         bus_q  <= bus_d;
         rdat_q <= rdat_d;
      end
   end

   // Register writes; only byte lane zero reaches the byte registers
   always_comb begin
      casc_d = casc_q;
      mask_d = mask_q;
      wr_mc  = '0;
      for (int c = 0; c < 2; c++) begin
         cmp_d[c] = cmp_q[c];
         cs_d[c]  = cs_q[c];
         mc_d[c]  = mc_q[c];
      end
      if (wr && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            OFS_CMP0:  cmp_d[0] = wb_dat_i[7:0];
            OFS_CMP1:  cmp_d[1] = wb_dat_i[7:0];
            OFS_CSEL0: cs_d[0]  = wb_dat_i[2:0];
            OFS_CSEL1: cs_d[1]  = wb_dat_i[2:0];
            OFS_MODE0: begin
               mc_d[0]  = wb_dat_i[7:0] & MC_STORE;
               wr_mc[0] = 1'b1;
            end
            OFS_MODE1: begin
               mc_d[1]  = wb_dat_i[7:0] & MC_STORE;
               wr_mc[1] = 1'b1;
            end
            OFS_MASK:  mask_d = wb_dat_i[1:0];
            OFS_CASC:  casc_d = wb_dat_i[0];
            default:   casc_d = casc_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_q  <= '{RST_BYTE, RST_BYTE};
         cs_q   <= '{CS_FALL, CS_FALL};
         mc_q   <= '{RST_BYTE, RST_BYTE};
         mask_q <= '0;
         casc_q <= 1'b0;
      end else begin
         cmp_q  <= cmp_d;
         cs_q   <= cs_d;
         mc_q   <= mc_d;
         mask_q <= mask_d;
         casc_q <= casc_d;
      end
   end

   // Counting; in cascade channel 1 takes channel 0's carry
   always_comb begin
      div_d = div_q + DIV_W'(1);
      for (int c = 0; c < 2; c++) begin
         tick[c] = sel_tick(cs_q[c], evin[c] & ~ev_prev_q[c],
                            ~evin[c] & ev_prev_q[c], div_q, c);
         run[c]  = casc_q ? mc_q[0][MC_RUN] : mc_q[c][MC_RUN];
      end
      hit16   = tick[0] && cnt_q[0] == cmp_q[0] && cnt_q[1] == cmp_q[1];
      tick[1] = casc_q ? (tick[0] && cnt_q[0] == CNT_TOP && !hit16) : tick[1];
      for (int c = 0; c < 2; c++) begin
         hit[c] = casc_q ? (c == 0 && hit16)
                         : (tick[c] && cnt_q[c] == cmp_q[c]);
         cnt_d[c] = cnt_q[c];
         ff_d[c]  = ff_q[c];
         if (!run[c])
            cnt_d[c] = '0;
         else if (casc_q && hit16)
            cnt_d[c] = '0;
         else if (tick[c] && !mc_q[c][MC_PWM] && !casc_q && hit[c])
            cnt_d[c] = '0;
         else if (tick[c])
            cnt_d[c] = cnt_q[c] + CNT_W'(1);
         // Output flip-flop; PWM sets on overflow and clears on match
         if (mc_q[c][MC_PWM] && !casc_q) begin
            if (run[c] && hit[c])
               ff_d[c] = 1'b0;
            else if (run[c] && tick[c] && cnt_q[c] == CNT_TOP)
               ff_d[c] = 1'b1;
         end else if (wr_mc[c] && wb_dat_i[MC_SET])
            ff_d[c] = 1'b1;
         else if (wr_mc[c] && wb_dat_i[MC_CLR])
            ff_d[c] = 1'b0;
         else if (run[c] && hit[c] && mc_q[c][MC_INV])
            ff_d[c] = ~ff_q[c];
         tout_d[c] = mc_q[c][MC_OE] &
                     (ff_q[c] ^ (mc_q[c][MC_PWM] & mc_q[c][MC_INV]));
         mirq_d[c] = run[c] & hit[c];
      end
      // Read of status clears only the bits it returned; a new set wins
      stat_d = stat_q;
      if (bus_q == BUS_ACK && wb_cyc_i && wb_stb_i && !wb_we_i &&
          wb_adr_i == OFS_STAT)
         stat_d = stat_q & ~rdat_q[1:0];
      stat_d = stat_d | mirq_d;
      irq_d  = |(stat_q & mask_q);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q     <= '{RST_BYTE, RST_BYTE};
         ff_q      <= '0;
         ev_prev_q <= '0;
         div_q     <= '0;
         stat_q    <= '0;
         tout_q    <= '0;
         mirq_q    <= '0;
         irq_q     <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         ff_q      <= ff_d;
         ev_prev_q <= evin;
         div_q     <= div_d;
         stat_q    <= stat_d;
         tout_q    <= tout_d;
         mirq_q    <= mirq_d;
         irq_q     <= irq_d;
      end
   end

   assign wb_dat_o      = rdat_q;
   assign wb_ack_o      = (bus_q == BUS_ACK);
   assign timer_out_ch0 = tout_q[0];
   assign timer_out_ch1 = tout_q[1];
   assign match_irq_ch0 = mirq_q[0];
   assign match_irq_ch1 = mirq_q[1];
   assign irq           = irq_q;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_cmp_reset;
      $fell(rst) |-> cmp_q[0] == RST_BYTE && cmp_q[1] == RST_BYTE;
   endproperty
   a_cmp_reset: assert property (p_cmp_reset)
      else $error("compare not zero after reset");

   property p_byte_lane;
      wr && !wb_sel_i[0] |=> $stable(cmp_q[0]) && $stable(cmp_q[1]);
   endproperty
   a_byte_lane: assert property (p_byte_lane)
      else $error("compare written without byte lane zero");

   property p_match_irq;
      run[0] && hit[0] |=> match_irq_ch0 && stat_q[0];
   endproperty
   a_match_irq: assert property (p_match_irq)
      else $error("match did not raise interrupt");

   property p_stop;
      !run[1] |=> cnt_q[1] == RST_BYTE;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stopped counter not zero");

   property p_restart;
      run[0] && !casc_q && !mc_q[0][MC_PWM] && hit[0] |=> cnt_q[0] == '0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("counter did not restart after match");

   property p_event;
      run[1] && !casc_q && cs_q[1] == CS_RISE && !hit[1] &&
      evin[1] && !ev_prev_q[1] |=> cnt_q[1] == $past(cnt_q[1]) + CNT_W'(1);
   endproperty
   a_event: assert property (p_event)
      else $error("rising event not counted");

   property p_square;
      run[0] && hit[0] && !casc_q && !mc_q[0][MC_PWM] && mc_q[0][MC_INV] &&
      !wr_mc[0] |=> ff_q[0] != $past(ff_q[0]);
   endproperty
   a_square: assert property (p_square)
      else $error("square wave did not toggle");

   property p_pwm_set;
      run[1] && !casc_q && mc_q[1][MC_PWM] && tick[1] &&
      cnt_q[1] == CNT_TOP && cmp_q[1] != CNT_TOP |=> ff_q[1];
   endproperty
   a_pwm_set: assert property (p_pwm_set)
      else $error("pwm level not set on overflow");

   property p_carry;
      casc_q && run[0] && tick[0] && cnt_q[0] == CNT_TOP && !hit16
      |=> cnt_q[1] == $past(cnt_q[1]) + CNT_W'(1);
   endproperty
   a_carry: assert property (p_carry)
      else $error("cascade carry lost");

   property p_tap0;
      cs_q[0] == 3'h2 |-> tick[0] == (div_q[2:0] == 3'h7);
   endproperty
   a_tap0: assert property (p_tap0)
      else $error("channel 0 prescaler tap wrong");

   c_cascade: cover property (casc_q && run[0] && hit16);
   c_pwm: cover property (mc_q[1][MC_PWM] && run[1] && hit[1]);
   c_clear: cover property (stat_q[0] ##1 !stat_q[0]);
endmodule : tmr_dual
`default_nettype wire

// *** dv/tmr_pin_model.sv ***
// Purpose: Far-side pin model, sends event pulses to a count input
// Assumes: Pulses are one clock high and one low, synchronous
// Notes:   Pin rests low between bursts, as a driven source would
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_model (
   // Clock
   input  wire logic       clk,
   // Burst request
   input  wire logic       go,
   input  wire logic [7:0] pulses,
   // Pin side
   output var  logic       pin,
   output var  logic       busy
);
   logic [8:0] left_q = '0;
   initial pin = 1'b0;
   assign busy = (left_q != 9'h000);
   // One toggle per clock gives one rising edge per pair of cycles
   always @(posedge clk) begin
      if (go) begin
         left_q <= {pulses, 1'b0};
      end else if (busy) begin
         left_q <= left_q - 9'h001;
      end
      pin <= busy ? ~pin : 1'b0;
   end
endmodule : tmr_pin_model
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the dual timer/event counter
// Assumes: One clock, classic Wishbone, answer after one cycle
// Notes:   Channel 0 event input is driven directly for falling edges
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import tmr_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, go = 1'b0, ev0 = 1'b0;
   logic [7:0]  adr = 8'h00, np = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0, rd, dat_o;
   logic        ack, ev1, busy, to0, to1, mi0, mi1, irq;
   int          bad_count = 0, samples_checked = 0, n;
   initial forever #5 clk = ~clk;
   tmr_dual u_tmr_dual (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .event_in_ch0(ev0),
      .event_in_ch1(ev1), .timer_out_ch0(to0), .timer_out_ch1(to1),
      .match_irq_ch0(mi0), .match_irq_ch1(mi1), .irq(irq));
   tmr_pin_model u_tmr_pin_model (.clk(clk), .go(go), .pulses(np),
      .pin(ev1), .busy(busy));
   task tally_and_finish;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int i;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      if (i >= 50) begin bad_count++; tally_and_finish(); end
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask : bus
   // Clocks between events: k 0/2 match ch0/ch1, k 1/3 output ch0/ch1
   task gap(input int k, output int cnt);
      int i;
      logic [3:0] p, now;
      logic hit, started;
      p = {to1, mi1, to0, mi0}; started = 1'b0; cnt = 0;
      for (i = 0; i < 9000; i++) begin
         @(posedge clk);
         now = {to1, mi1, to0, mi0};
         hit = k[0] ? (now[k] !== p[k]) : (now[k] === 1'b1);
         p = now;
         if (hit && started) break;
         if (hit) begin started = 1'b1; cnt = 0; end
         cnt++;
      end
      if (i == 9000) begin bad_count++; tally_and_finish(); end
   endtask : gap
   task t_regs;
      bus(1'b0, OFS_CMP0, 32'h0, 4'hF); check(rd, 32'h0);
      bus(1'b0, OFS_CMP1, 32'h0, 4'hF); check(rd, 32'h0);
      check({31'h0, to0}, 32'h0);
      bus(1'b1, OFS_CMP0, 32'hFF, 4'h1);
      bus(1'b1, OFS_CMP0, 32'h11, 4'h0);
      bus(1'b0, OFS_CMP0, 32'h0, 4'hF); check(rd, 32'hFF);
      bus(1'b1, OFS_CMP1, 32'h00, 4'h1);
      bus(1'b0, OFS_CMP1, 32'h0, 4'hF); check(rd, 32'h00);
      bus(1'b1, 8'h3C, 32'h5A, 4'hF);
      bus(1'b0, 8'h3C, 32'h0, 4'hF); check(rd, 32'h0);
   endtask : t_regs
   task t_interval;
      bus(1'b1, OFS_CMP0, 32'h02, 4'h1);
      bus(1'b1, OFS_CSEL0, 32'h02, 4'h1);
      bus(1'b1, OFS_MODE0, 32'h80, 4'h1);
      gap(0, n); check(n, 32'd24);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, OFS_MODE0, 32'h00, 4'h1);
      bus(1'b0, OFS_CNT0, 32'h0, 4'hF); check(rd, 32'h0);
      bus(1'b1, OFS_MASK, 32'h01, 4'h1);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, OFS_STAT, 32'h0, 4'hF); check(rd, 32'h1);
      bus(1'b0, OFS_STAT, 32'h0, 4'hF); check(rd, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
   endtask : t_interval
   task t_square;
      // Timer stopped above before the mode is changed
      bus(1'b1, OFS_MODE0, 32'h83, 4'h1);
      gap(1, n); check(n, 32'd24);
      gap(1, n); check(n, 32'd24);
      bus(1'b1, OFS_MODE0, 32'h00, 4'h1);
   endtask : t_square
   task t_event;
      int i;
      bus(1'b1, OFS_CMP1, 32'hFF, 4'h1);
      bus(1'b1, OFS_CSEL1, 32'h01, 4'h1);
      bus(1'b1, OFS_MODE1, 32'h80, 4'h1);
      @(posedge clk);
      go <= 1'b1; np <= 8'h05;
      @(posedge clk);
      go <= 1'b0;
      // The model raises busy at the edge that takes go; it is sampled one edge later
      @(posedge clk);
      for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
      if (i == 100) begin bad_count++; tally_and_finish(); end
      repeat (3) @(posedge clk);
      bus(1'b0, OFS_CNT1, 32'h0, 4'hF); check(rd, 32'h05);
      bus(1'b1, OFS_MODE1, 32'h00, 4'h1);
      bus(1'b0, OFS_CNT1, 32'h0, 4'hF); check(rd, 32'h00);
   endtask : t_event
   task t_pwm;
      bus(1'b0, OFS_STAT, 32'h0, 4'hF);            // Clears old status
      bus(1'b1, OFS_CMP1, 32'h40, 4'h1);
      bus(1'b1, OFS_CSEL1, 32'h02, 4'h1);
      bus(1'b1, OFS_MODE1, 32'hC1, 4'h1);
      // High for cmp+1 ticks of 16 clocks, period 256 ticks
      gap(3, n);
      check(n, (to1 === 1'b1) ? 32'd3056 : 32'd1040);
      gap(2, n); check(n, 32'd4096);
      bus(1'b1, OFS_MODE1, 32'h00, 4'h1);
      bus(1'b0, OFS_STAT, 32'h0, 4'hF); check(rd, 32'h2);
   endtask : t_pwm
   task t_cascade;
      // Channel 0 is stopped here, so the compare pair may be written
      bus(1'b1, OFS_CASC, 32'h01, 4'h1);
      bus(1'b1, OFS_CMP0, 32'h03, 4'h1);
      bus(1'b1, OFS_CMP1, 32'h01, 4'h1);
      bus(1'b1, OFS_MODE0, 32'h80, 4'h1);
      // Compare 0103 gives 260 ticks of 8 clocks
      gap(0, n); check(n, 32'd2080);
      bus(1'b1, OFS_MODE0, 32'h00, 4'h1);
      bus(1'b0, OFS_STAT, 32'h0, 4'hF); check(rd, 32'h1);
      bus(1'b1, OFS_CASC, 32'h00, 4'h1);
   endtask : t_cascade
   task t_fall;
      int i;
      bus(1'b1, OFS_CMP0, 32'hFF, 4'h1);
      bus(1'b1, OFS_CSEL0, 32'h00, 4'h1);
      bus(1'b1, OFS_MODE0, 32'h80, 4'h1);
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         ev0 <= ~ev0;
      end
      repeat (2) @(posedge clk);
      bus(1'b0, OFS_CNT0, 32'h0, 4'hF); check(rd, 32'h03);
   endtask : t_fall
   task t_reset;
      // Second reset with channel 0 counting and its compare at FF
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, OFS_CMP0, 32'h0, 4'hF); check(rd, 32'h0);
      bus(1'b0, OFS_MODE0, 32'h0, 4'hF); check(rd, 32'h0);
      bus(1'b0, OFS_CNT0, 32'h0, 4'hF); check(rd, 32'h0);
   endtask : t_reset
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_interval();
      t_square();
      t_event();
      t_pwm();
      t_cascade();
      t_fall();
      t_reset();
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
